// ==== fix_gated_second_pulse.sv ====
`timescale 1ns/1ns
module fix_gated_second_pulse
#(
   parameter second_pulse_pkg::fix_gate_t FIX_GATE = second_pulse_pkg::GATE_FIX_3D,
   parameter int unsigned PULSE_WIDTH_CYCLES  = second_pulse_pkg::PULSE_WIDTH_CYCLES,
   parameter int unsigned PULSE_PERIOD_CYCLES = second_pulse_pkg::PULSE_PERIOD_CYCLES
)
(
   input  wire logic                                       ref_clk,
   input  wire logic                                       resetn,
   input  wire logic                                       fix_valid,
   input  wire logic                                       fix_is_3d,
   input  wire logic                                       second_mark,
   input  wire logic                                       rtc_xtal,
   input  wire logic                                       time_set,
   input  wire logic [second_pulse_pkg::RTC_SECONDS_W-1:0] time_set_seconds,
   output logic                                            second_timing_pulse,
   output logic                                            pulse_locked,
   output logic      [second_pulse_pkg::RTC_SECONDS_W-1:0] rtc_seconds,
   output logic                                            rtc_second_tick
);

   localparam int unsigned W = second_pulse_pkg::CYCLE_CNT_W;
   localparam logic [W-1:0] WIDTH_LAST  = W'(PULSE_WIDTH_CYCLES - 1);
   localparam logic [W-1:0] PERIOD_LAST = W'(PULSE_PERIOD_CYCLES - 1);
   localparam logic [W-1:0] CNT_ZERO    = '0;
   localparam logic [W-1:0] CNT_ONE     = W'(1);

   second_pulse_pkg::pulse_state_t state;
   second_pulse_pkg::pulse_state_t next_state;
   logic [W-1:0] period_cnt;
   logic [W-1:0] next_period_cnt;
   logic [W-1:0] width_cnt;
   logic [W-1:0] next_width_cnt;
   logic         next_second_timing_pulse;
   logic         next_pulse_locked;
   logic         gate_ok;
   logic         period_end;
   logic         fire;

   // fix condition selected at build time
   function automatic logic fix_gate_met
   (
      input second_pulse_pkg::fix_gate_t mode,
      input logic                        valid,
      input logic                        is_3d
   );
      logic met;
      met = 1'b0;
      case (mode)
         second_pulse_pkg::GATE_FIX_3D:   met = valid & is_3d;
         second_pulse_pkg::GATE_FIX_2D:   met = valid;
         second_pulse_pkg::GATE_POWER_UP: met = 1'b1;
         default:                         met = 1'b0;
      endcase
      return met;
   endfunction

   assign gate_ok    = fix_gate_met(FIX_GATE, fix_valid, fix_is_3d);
   assign period_end = (period_cnt == PERIOD_LAST);
   // a missing mark is bridged by the local one-second count (flywheel)
   assign fire       = second_mark | period_end;

   always_comb
   begin
      next_state      = state;
      next_period_cnt = period_cnt + CNT_ONE;
      next_width_cnt  = width_cnt;
      if (fire)
      begin
         // each mark realigns the local second to navigation time
         next_period_cnt = CNT_ZERO;
      end
      case (state)
         second_pulse_pkg::ST_IDLE:
         begin
            if (gate_ok)
            begin
               next_state = second_pulse_pkg::ST_ARMED;
            end
         end
         second_pulse_pkg::ST_ARMED:
         begin
            // power-up mode has no mark to wait for, so the local count may start it
            if (second_mark || (FIX_GATE == second_pulse_pkg::GATE_POWER_UP && period_end))
            begin
               next_state     = second_pulse_pkg::ST_HIGH;
               next_width_cnt = CNT_ZERO;
            end
         end
         second_pulse_pkg::ST_HIGH:
         begin
            if (fire)
            begin
               // an early mark restarts the high time; the pulse stays high, with no new rising edge
               next_width_cnt = CNT_ZERO;
            end
            else if (width_cnt == WIDTH_LAST)
            begin
               next_state = second_pulse_pkg::ST_LOW;
            end
            else
            begin
               next_width_cnt = width_cnt + CNT_ONE;
            end
         end
         second_pulse_pkg::ST_LOW:
         begin
            if (fire)
            begin
               next_state     = second_pulse_pkg::ST_HIGH;
               next_width_cnt = CNT_ZERO;
            end
         end
         default:
         begin
            next_state = second_pulse_pkg::ST_IDLE;
         end
      endcase
      if (!gate_ok)
      begin
         next_state     = second_pulse_pkg::ST_IDLE;
         next_width_cnt = CNT_ZERO;
      end
      next_second_timing_pulse = (next_state == second_pulse_pkg::ST_HIGH);
      next_pulse_locked        = (next_state == second_pulse_pkg::ST_HIGH)
                               || (next_state == second_pulse_pkg::ST_LOW);
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state               <= second_pulse_pkg::ST_IDLE;
         period_cnt          <= CNT_ZERO;
         width_cnt           <= CNT_ZERO;
         second_timing_pulse <= 1'b0;
         pulse_locked        <= 1'b0;
      end
      else
      begin
         state               <= next_state;
         period_cnt          <= next_period_cnt;
         width_cnt           <= next_width_cnt;
         second_timing_pulse <= next_second_timing_pulse;
         pulse_locked        <= next_pulse_locked;
      end
   end

   // coarse time source; survives only as long as its reset is not asserted
   rtc_keeper u_rtc
   (
      .ref_clk          (ref_clk),
      .resetn           (resetn),
      .rtc_xtal         (rtc_xtal),
      .time_set         (time_set),
      .time_set_seconds (time_set_seconds),
      .rtc_seconds      (rtc_seconds),
      .rtc_second_tick  (rtc_second_tick)
   );

endmodule

// ==== second_pulse_pkg.sv ====
package second_pulse_pkg;

   // reference clock and derived cycle counts
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned PULSE_WIDTH_MS  = 100;
   localparam int unsigned PULSE_PERIOD_MS = 1000;
   localparam int unsigned MS_PER_S        = 1000;
   // exact division at 125 MHz, so the rounding direction does not matter here
   localparam int unsigned PULSE_WIDTH_CYCLES  = (CLK_HZ / MS_PER_S) * PULSE_WIDTH_MS;
   localparam int unsigned PULSE_PERIOD_CYCLES = (CLK_HZ / MS_PER_S) * PULSE_PERIOD_MS;
   localparam int unsigned CYCLE_CNT_W         = 27;

   // low-rate real-time clock crystal
   localparam int unsigned RTC_XTAL_HZ  = 32768;
   localparam int unsigned RTC_PRESC_W  = 15;
   localparam int unsigned RTC_SECONDS_W = 32;
   localparam logic [RTC_PRESC_W-1:0]   RTC_PRESC_LAST  = 15'h7fff;
   localparam logic [RTC_PRESC_W-1:0]   RTC_PRESC_RESET = 15'h0000;
   localparam logic [RTC_SECONDS_W-1:0] RTC_SECONDS_RESET = 32'h0000_0000;

   // fix quality needed before the pulse is driven (build-time option)
   typedef enum logic [1:0]
   {
      GATE_FIX_3D   = 2'h0,
      GATE_FIX_2D   = 2'h1,
      GATE_POWER_UP = 2'h2
   } fix_gate_t;

   // gray along idle -> armed -> high <-> low
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'h0,
      ST_ARMED = 2'h1,
      ST_HIGH  = 2'h3,
      ST_LOW   = 2'h2
   } pulse_state_t;

endpackage

// ==== rtc_keeper.sv ====
`timescale 1ns/1ns
module rtc_keeper
(
   input  wire logic                                       ref_clk,
   input  wire logic                                       resetn,
   input  wire logic                                       rtc_xtal,
   input  wire logic                                       time_set,
   input  wire logic [second_pulse_pkg::RTC_SECONDS_W-1:0] time_set_seconds,
   output logic      [second_pulse_pkg::RTC_SECONDS_W-1:0] rtc_seconds,
   output logic                                            rtc_second_tick
);

   logic                                       xtal_meta;
   logic                                       xtal_sync;
   logic                                       xtal_prev;
   logic [second_pulse_pkg::RTC_PRESC_W-1:0]   presc;
   logic [second_pulse_pkg::RTC_PRESC_W-1:0]   next_presc;
   logic [second_pulse_pkg::RTC_SECONDS_W-1:0] next_rtc_seconds;
   logic                                       next_rtc_second_tick;
   logic                                       xtal_rise;

   // crystal is asynchronous to ref_clk; only xtal_sync is looked at
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
         xtal_prev <= 1'b0;
      end
      else
      begin
         xtal_meta <= rtc_xtal;
         xtal_sync <= xtal_meta;
         xtal_prev <= xtal_sync;
      end
   end

   assign xtal_rise = xtal_sync & ~xtal_prev;

   always_comb
   begin
      next_presc           = presc;
      next_rtc_seconds     = rtc_seconds;
      next_rtc_second_tick = 1'b0;
      if (xtal_rise)
      begin
         if (presc == second_pulse_pkg::RTC_PRESC_LAST)
         begin
            next_presc           = second_pulse_pkg::RTC_PRESC_RESET;
            next_rtc_seconds     = rtc_seconds + 32'h0000_0001;
            next_rtc_second_tick = 1'b1;
         end
         else
         begin
            next_presc = presc + 15'h0001;
         end
      end
      // a set from navigation time wins over the crystal count
      if (time_set)
      begin
         // no tick on a load: the seconds value did not step by one
         next_presc           = second_pulse_pkg::RTC_PRESC_RESET;
         next_rtc_seconds     = time_set_seconds;
         next_rtc_second_tick = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         presc           <= second_pulse_pkg::RTC_PRESC_RESET;
         rtc_seconds     <= second_pulse_pkg::RTC_SECONDS_RESET;
         rtc_second_tick <= 1'b0;
      end
      else
      begin
         presc           <= next_presc;
         rtc_seconds     <= next_rtc_seconds;
         rtc_second_tick <= next_rtc_second_tick;
      end
   end

endmodule

// ==== fix_pulse_checker_assertions.sv ====
`timescale 1ns/1ns
module fix_pulse_checker
#(
   parameter second_pulse_pkg::fix_gate_t FIX_GATE = second_pulse_pkg::GATE_FIX_3D,
   parameter int unsigned PULSE_WIDTH_CYCLES  = 10,
   parameter int unsigned PULSE_PERIOD_CYCLES = 100
)
(
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        fix_valid,
   input wire logic        fix_is_3d,
   input wire logic        second_mark,
   input wire logic        rtc_xtal,
   input wire logic        time_set,
   input wire logic [31:0] time_set_seconds,
   input wire logic        second_timing_pulse,
   input wire logic        pulse_locked,
   input wire logic [31:0] rtc_seconds,
   input wire logic        rtc_second_tick
);
   logic gate;
   logic prev_gate;
   int   high_cnt;
   int   gap;
   // power-up mode never blocks; 2d mode ignores the dimension flag
   assign gate = FIX_GATE == second_pulse_pkg::GATE_POWER_UP ||
                 fix_valid && (fix_is_3d || FIX_GATE == second_pulse_pkg::GATE_FIX_2D);
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prev_gate <= 1'h0;
         high_cnt  <= 0;
         gap       <= 0;
      end
      else
      begin
         prev_gate <= gate;
         high_cnt  <= second_timing_pulse ? high_cnt + 1 : 0;
         gap       <= $rose(second_timing_pulse) ? 1 : gap + 1;
      end
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   mark_fire_a:
      assert property (second_mark && gate && prev_gate |=> second_timing_pulse)
      else $error("pulse did not follow a second mark");
   first_mark_a:
      assert property (second_mark && gate && !prev_gate |=> !second_timing_pulse)
      else $error("mark on gate rise was used");
   gate_off_a:
      assert property (!gate |=> !second_timing_pulse && !pulse_locked)
      else $error("pulse driven without the fix condition");
   pulse_width_a:
      assert property ($fell(second_timing_pulse) && $past(gate) |-> high_cnt == PULSE_WIDTH_CYCLES)
      else $error("pulse high time wrong");
   flywheel_period_a:
      assert property (pulse_locked && gate && gap == PULSE_PERIOD_CYCLES - 1
                       |=> $rose(second_timing_pulse))
      else $error("local period did not fire");
   lock_start_a:
      assert property ($rose(pulse_locked) |-> second_timing_pulse)
      else $error("lock without a pulse");
   rtc_load_a:
      assert property (time_set |=> rtc_seconds == $past(time_set_seconds))
      else $error("time load missed");
   rtc_hold_a:
      assert property ($changed(rtc_seconds) |-> rtc_second_tick || $past(time_set))
      else $error("time changed without cause");
   rtc_step_a:
      assert property (rtc_second_tick |-> rtc_seconds == $past(rtc_seconds) + 32'h1)
      else $error("time step not one");
endmodule
bind fix_gated_second_pulse fix_pulse_checker
#(
   .FIX_GATE            (FIX_GATE),
   .PULSE_WIDTH_CYCLES  (PULSE_WIDTH_CYCLES),
   .PULSE_PERIOD_CYCLES (PULSE_PERIOD_CYCLES)
)
fix_pulse_checker_inst
(
   .ref_clk             (ref_clk),
   .resetn              (resetn),
   .fix_valid           (fix_valid),
   .fix_is_3d           (fix_is_3d),
   .second_mark         (second_mark),
   .rtc_xtal            (rtc_xtal),
   .time_set            (time_set),
   .time_set_seconds    (time_set_seconds),
   .second_timing_pulse (second_timing_pulse),
   .pulse_locked        (pulse_locked),
   .rtc_seconds         (rtc_seconds),
   .rtc_second_tick     (rtc_second_tick)
);

// ==== second_pulse_sampler.sv ====
`timescale 1ns/1ns
module second_pulse_sampler
(
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic pulse,
   output int        width,
   output int        spacing
);
   logic prev;
   int   hi;
   int   gap;
   // spacing is timed from rising edges only; the falling edge just closes the width
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prev    <= 1'h0;
         hi      <= 0;
         gap     <= 0;
         width   <= 0;
         spacing <= 0;
      end
      else
      begin
         prev <= pulse;
         hi   <= pulse ? hi + 1 : 0;
         gap  <= (pulse && !prev) ? 1 : gap + 1;
         if (pulse && !prev)
            spacing <= gap;
         if (!pulse && prev)
            width <= hi;
      end
   end
endmodule

// ==== fix_gated_second_pulse_tb.sv ====
`timescale 1ns/1ns
module fix_gated_second_pulse_tb;
   localparam int W = 10;
   localparam int P = 100;
   logic        ref_clk = 1'h0;
   logic        resetn = 1'h0;
   logic        fix_valid = 1'h0;
   logic        fix_is_3d = 1'h0;
   logic        second_mark = 1'h0;
   logic        rtc_xtal = 1'h0;
   logic        time_set = 1'h0;
   logic [31:0] time_set_seconds = 32'h0;
   wire  [2:0]  pulse;
   wire  [2:0]  locked;
   wire  [2:0]  tick;
   wire  [31:0] rtc [3];
   logic [2:0]  seen;
   logic [15:0] rnd = 16'h6;
   int          width;
   int          spacing;
   int          d;
   int          last_d;
   int          n_fail = 0;
   int          checks_done = 0;
   always #4 ref_clk = ~ref_clk;
   // true crystal rate: no rtc second falls inside this short run
   always #15259 rtc_xtal = ~rtc_xtal;
   // instance g uses gate option g: 3d, 2d, power-up
   for (genvar g = 0; g < 3; g++)
   begin : gate_opt
      fix_gated_second_pulse
      #(
         .FIX_GATE            (second_pulse_pkg::fix_gate_t'(g)),
         .PULSE_WIDTH_CYCLES  (W),
         .PULSE_PERIOD_CYCLES (P)
      )
      fix_gated_second_pulse_inst
      (
         .ref_clk             (ref_clk),
         .resetn              (resetn),
         .fix_valid           (fix_valid),
         .fix_is_3d           (fix_is_3d),
         .second_mark         (second_mark),
         .rtc_xtal            (rtc_xtal),
         .time_set            (time_set),
         .time_set_seconds    (time_set_seconds),
         .second_timing_pulse (pulse[g]),
         .pulse_locked        (locked[g]),
         .rtc_seconds         (rtc[g]),
         .rtc_second_tick     (tick[g])
      );
   end
   second_pulse_sampler second_pulse_sampler_inst
   (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .pulse   (pulse[0]),
      .width   (width),
      .spacing (spacing)
   );
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // early marks only, always past the end of the high time
   function automatic int gap_of(input logic [15:0] s);
      return P - 20 + int'(s[3:0]);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic mark();
      second_mark <= 1'h1;
      @(posedge ref_clk);
      second_mark <= 1'h0;
   endtask
   task automatic watch(input int n);
      seen = 3'h0;
      repeat (n)
      begin
         @(negedge ref_clk);
         seen |= pulse;
      end
      @(posedge ref_clk);
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      cyc(2);
      resetn <= 1'h1;
      cyc(20);
      fix_valid <= 1'h1;
      fix_is_3d <= 1'h1;
      mark();
      // power-up copy fired on that mark; let its pulse end before the next one
      cyc(W + 2);
      cmp("pulse", 32'h0, 32'(pulse[0]));
      last_d = 0;
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr_next(rnd);
         d = gap_of(rnd);
         mark();
         cyc(d - 1);
         if (i > 0)
         begin
            cmp("spacing", last_d, spacing);
            cmp("width", W, width);
         end
         last_d = d;
      end
      cyc(2 * P + 10);
      cmp("flywheel", P, spacing);
      cmp("locked", 32'h1, 32'(locked[0]));
      fix_is_3d <= 1'h0;
      cyc(2);
      cmp("locked", 32'h0, 32'(locked[0]));
      watch(2 * P);
      cmp("seen", 32'h6, 32'(seen));
      fix_valid <= 1'h0;
      cyc(2);
      watch(2 * P);
      cmp("seen", 32'h4, 32'(seen));
      for (int i = 0; i < 2; i++)
      begin
         rnd = lfsr_next(rnd);
         time_set_seconds <= {rnd, ~rnd};
         time_set <= 1'h1;
         cyc(1);
         time_set <= 1'h0;
         cyc(1);
         cmp("rtc", {rnd, ~rnd}, rtc[0]);
      end
      cmp("tick", 32'h0, 32'(tick));
      report_and_stop();
   end
endmodule
